// ### dmx_pkg.sv
// Constants and types for the data-move execute block.
// Assumes an instruction word of 16 bits and a 4096-byte data space.
package dmx_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int          INSTR_W        = 16;
    localparam int          DATA_W         = 8;
    localparam int          ADDR_W         = 12;
    localparam int          BANK_W         = 4;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [5:0]  ENC_MOVE_FILE  = 6'h14;
    localparam logic [6:0]  ENC_STORE_W    = 7'h37;
    localparam logic [7:0]  ENC_LOAD_W_LIT = 8'h0e;
    localparam logic [7:0]  ENC_LOAD_BANK  = 8'h01;
    localparam logic [3:0]  ENC_FF_FIRST   = 4'hc;
    localparam logic [3:0]  ENC_FF_SECOND  = 4'hf;

    // ------------------------------------------------------------
    // Field positions and address constants
    // ------------------------------------------------------------
    localparam int          BIT_DEST       = 9;
    localparam int          BIT_ACCESS     = 8;
    localparam logic [7:0]  INDEXED_MAX    = 8'h5f;
    localparam logic [3:0]  ACCESS_LO_PAGE = 4'h0;
    localparam logic [3:0]  ACCESS_HI_PAGE = 4'hf;
    localparam logic [3:0]  BANK_UPPER_RST = 4'h0;
    localparam logic [11:0] WORKING_ADDR_DFLT = 12'hfe8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  WORKING_RST    = 8'h00;
    localparam logic [3:0]  BANK_RST       = 4'h0;

    typedef enum logic [1:0] {
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE
    } dmx_phase_t;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_MOVE_FILE,
        OP_STORE_W,
        OP_LOAD_W_LIT,
        OP_LOAD_BANK,
        OP_FF_SRC,
        OP_FF_DST
    } dmx_op_t;

endpackage

// ### dmx_addr.sv
// Effective data address for an 8-bit file field.
// Assumes bank and index base are stable in the decode phase.
`timescale 1ns/1ps
module dmx_addr (
    // File field and selectors
    input  wire logic [7:0]  i_file,
    input  wire logic        i_banked,
    input  wire logic [3:0]  i_bank,
    input  wire logic        i_ext_en,
    input  wire logic [11:0] i_index_base,
    // Result
    output logic      [11:0] o_addr
);
    import dmx_pkg::*;

    always_comb begin
        if (i_banked) begin
            o_addr = {i_bank, i_file};
        end else if (i_ext_en && (i_file <= INDEXED_MAX)) begin
            o_addr = i_index_base + {ACCESS_LO_PAGE, i_file};
        end else if (i_file[7]) begin
            o_addr = {ACCESS_HI_PAGE, i_file};
        end else begin
            o_addr = {ACCESS_LO_PAGE, i_file};
        end
    end

endmodule

// ### dmx_exec.sv
// Execute logic for the data-move instruction group.
// Assumes an external data memory answering a read one cycle after its strobe.
`timescale 1ns/1ps
module dmx_exec #(
    parameter logic [11:0] WORKING_ADDR = dmx_pkg::WORKING_ADDR_DFLT,
    parameter int          ADDR_W       = dmx_pkg::ADDR_W
) (
    // Clock and reset
    input  wire logic                      i_mclk,
    input  wire logic                      i_rst,
    // Instruction feed
    input  wire logic [dmx_pkg::INSTR_W-1:0] i_instr,
    input  wire logic                      i_instr_valid,
    input  wire logic                      i_ext_en,
    input  wire logic [11:0]               i_index_base,
    // Data memory read
    output logic                           o_rd_en,
    output logic      [11:0]               o_rd_addr,
    input  wire logic [7:0]                i_rd_data,
    // Data memory write
    output logic                           o_wr_en,
    output logic      [11:0]               o_wr_addr,
    output logic      [7:0]                o_wr_data,
    // Core state
    output logic      [7:0]                o_working,
    output logic      [7:0]                o_bank_select_register,
    output logic                           o_flag_n,
    output logic                           o_flag_z,
    output logic      [1:0]                o_phase,
    output logic                           o_second_word_wait,
    output logic                           o_done
);
    import dmx_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W != 12) begin : g_bad_width
        $error("dmx_exec serves a 12-bit data space only");
    end

    dmx_phase_t  phase;
    dmx_op_t     op;
    dmx_op_t     next_op;
    logic [7:0]  lit;
    logic        dest_file;
    logic [11:0] tgt;
    logic [11:0] next_tgt;
    logic [11:0] res_addr;
    logic [7:0]  opnd;
    logic [7:0]  ff_data;
    logic [7:0]  operand_now;
    logic        tgt_is_w;

    // ------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            phase <= PH_DECODE;
        end else begin
            case (phase)
                PH_DECODE:  phase <= PH_READ;
                PH_READ:    phase <= PH_PROCESS;
                PH_PROCESS: phase <= PH_WRITE;
                PH_WRITE:   phase <= PH_DECODE;
                default:    phase <= PH_DECODE;
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_phase <= 2'h0;
        end else begin
            o_phase <= 2'(phase + 2'h1);
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    dmx_addr dmx_addr_inst (
        .i_file       (i_instr[7:0]),
        .i_banked     (i_instr[BIT_ACCESS]),
        .i_bank       (o_bank_select_register[BANK_W-1:0]),
        .i_ext_en     (i_ext_en),
        .i_index_base (i_index_base),
        .o_addr       (res_addr)
    );

    always_comb begin
        next_op = OP_NONE;
        if (!i_instr_valid) begin
            next_op = OP_NONE;
        end else if (o_second_word_wait) begin
            // A wrong second word drops the pending move
            if (i_instr[15:12] == ENC_FF_SECOND) begin
                next_op = OP_FF_DST;
            end
        end else if (i_instr[15:10] == ENC_MOVE_FILE) begin
            next_op = OP_MOVE_FILE;
        end else if (i_instr[15:9] == ENC_STORE_W) begin
            next_op = OP_STORE_W;
        end else if (i_instr[15:8] == ENC_LOAD_W_LIT) begin
            next_op = OP_LOAD_W_LIT;
        end else if (i_instr[15:8] == ENC_LOAD_BANK) begin
            next_op = OP_LOAD_BANK;
        end else if (i_instr[15:12] == ENC_FF_FIRST) begin
            next_op = OP_FF_SRC;
        end
        if ((next_op == OP_FF_SRC) || (next_op == OP_FF_DST)) begin
            next_tgt = i_instr[11:0];
        end else begin
            next_tgt = res_addr;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            op        <= OP_NONE;
            lit       <= 8'h00;
            dest_file <= 1'b0;
            tgt       <= 12'h000;
        end else if (phase == PH_DECODE) begin
            op        <= next_op;
            lit       <= i_instr[7:0];
            dest_file <= i_instr[BIT_DEST];
            tgt       <= next_tgt;
        end
    end

    assign tgt_is_w = (tgt == WORKING_ADDR);

    // ------------------------------------------------------------
    // Operand read
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_rd_en   <= 1'b0;
            o_rd_addr <= 12'h000;
        end else if (phase == PH_DECODE) begin
            // Working register is read internally, not from memory
            o_rd_en   <= ((next_op == OP_MOVE_FILE) || (next_op == OP_FF_SRC)) &&
                         (next_tgt != WORKING_ADDR);
            o_rd_addr <= next_tgt;
        end else begin
            o_rd_en   <= 1'b0;
        end
    end

    assign operand_now = tgt_is_w ? o_working : i_rd_data;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            opnd    <= 8'h00;
            ff_data <= 8'h00;
        end else if (phase == PH_PROCESS) begin
            opnd <= operand_now;
            if (op == OP_FF_SRC) begin
                ff_data <= operand_now;
            end
        end
    end

    // ------------------------------------------------------------
    // Destination write
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_wr_en   <= 1'b0;
            o_wr_addr <= 12'h000;
            o_wr_data <= 8'h00;
        end else if (phase == PH_PROCESS) begin
            o_wr_addr <= tgt;
            o_wr_en   <= 1'b0;
            o_wr_data <= operand_now;
            case (op)
                OP_MOVE_FILE: begin
                    o_wr_en   <= dest_file && !tgt_is_w;
                    o_wr_data <= operand_now;
                end
                OP_STORE_W: begin
                    o_wr_en   <= !tgt_is_w;
                    o_wr_data <= o_working;
                end
                OP_FF_DST: begin
                    o_wr_en   <= !tgt_is_w;
                    o_wr_data <= ff_data;
                end
                default: begin
                    o_wr_en   <= 1'b0;
                end
            endcase
        end else begin
            o_wr_en <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Working register and flags
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_working <= WORKING_RST;
        end else if (phase == PH_WRITE) begin
            case (op)
                OP_MOVE_FILE: begin
                    if (!dest_file || tgt_is_w) begin
                        o_working <= opnd;
                    end
                end
                OP_LOAD_W_LIT: o_working <= lit;
                OP_FF_DST: begin
                    if (tgt_is_w) begin
                        o_working <= ff_data;
                    end
                end
                default: o_working <= o_working;
            endcase
        end
    end

    // Only the register move touches negative and zero
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_flag_n <= 1'b0;
            o_flag_z <= 1'b0;
        end else if ((phase == PH_WRITE) && (op == OP_MOVE_FILE)) begin
            o_flag_n <= opnd[DATA_W-1];
            o_flag_z <= (opnd == 8'h00);
        end
    end

    // ------------------------------------------------------------
    // Bank select
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_bank_select_register <= {BANK_UPPER_RST, BANK_RST};
        end else if ((phase == PH_WRITE) && (op == OP_LOAD_BANK)) begin
            o_bank_select_register <= {BANK_UPPER_RST, lit[BANK_W-1:0]};
        end
    end

    // ------------------------------------------------------------
    // Two-word move tracking and completion
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_second_word_wait <= 1'b0;
        end else if ((phase == PH_WRITE) && (op == OP_FF_SRC)) begin
            o_second_word_wait <= 1'b1;
        end else if ((phase == PH_DECODE) && i_instr_valid) begin
            o_second_word_wait <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_done <= 1'b0;
        end else begin
            o_done <= (phase == PH_WRITE) && (op != OP_NONE) && (op != OP_FF_SRC);
        end
    end

endmodule

// ### dmx_exec_chk.sv
// Checker for the data-move execute block.
// Assumes it is bound to dmx_exec and sees only its ports.
`timescale 1ns/1ps
module dmx_exec_chk #(
    parameter logic [11:0] WORKING_ADDR = 12'hfe8,
    parameter int          ADDR_W       = 12
) (
    // Watched ports
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic [15:0] i_instr,
    input wire logic        i_instr_valid,
    input wire logic        i_ext_en,
    input wire logic [11:0] i_index_base,
    input wire logic        o_rd_en,
    input wire logic [11:0] o_rd_addr,
    input wire logic [7:0]  i_rd_data,
    input wire logic        o_wr_en,
    input wire logic [11:0] o_wr_addr,
    input wire logic [7:0]  o_wr_data,
    input wire logic [7:0]  o_working,
    input wire logic [7:0]  o_bank_select_register,
    input wire logic        o_flag_n,
    input wire logic        o_flag_z,
    input wire logic [1:0]  o_phase,
    input wire logic        o_second_word_wait,
    input wire logic        o_done
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic take;
    logic take2;
    assign take  = o_phase == 2'h0 && i_instr_valid && !o_second_word_wait;
    assign take2 = o_phase == 2'h0 && i_instr_valid && o_second_word_wait;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    phase_order_a: assert property (o_phase == 2'h0 |=> o_phase == 2'h1 ##1 o_phase == 2'h2 ##1 o_phase == 2'h3
        ##1 o_phase == 2'h0) else $error("phase order");
    strobe_phase_a: assert property ((o_rd_en |-> o_phase == 2'h1) and (o_wr_en |-> o_phase == 2'h3))
        else $error("strobe phase");
    bank_upper_a: assert property (o_bank_select_register[7:4] == 4'h0) else $error("bank upper bits");
    bank_load_a: assert property (take && i_instr[15:8] == 8'h01 |-> ##4 o_done
        && o_bank_select_register == {4'h0, $past(i_instr[3:0], 4)}) else $error("bank load");
    wlit_load_a: assert property (take && i_instr[15:8] == 8'h0e |-> ##4 o_done && o_working == $past(i_instr[7:0], 4)
        && {o_flag_n, o_flag_z} == $past({o_flag_n, o_flag_z}, 4)) else $error("literal load");
    store_w_a: assert property (take && i_instr[15:8] == 8'h6e && i_instr[7:5] == 3'h3 |=> !o_rd_en ##2 o_wr_en
        && o_wr_addr == {4'h0, $past(i_instr[7:0], 3)} && o_wr_data == o_working ##1 $stable(o_working))
        else $error("store working");
    move_w_a: assert property (take && i_instr[15:8] == 8'h50 && i_instr[7:5] == 3'h3 |=> o_rd_en
        && o_rd_addr == {4'h0, $past(i_instr[7:0])} ##3 o_working == $past(i_rd_data, 2)
        && o_flag_n == o_working[7] && o_flag_z == (o_working == 8'h00)) else $error("move to working");
    move_back_a: assert property (take && i_instr[15:8] == 8'h53 && o_bank_select_register[3:0] != 4'hf
        |=> o_rd_en && o_rd_addr == {o_bank_select_register[3:0], $past(i_instr[7:0])} ##2 o_wr_en
        && o_wr_addr == o_rd_addr && o_wr_data == $past(i_rd_data) ##1 $stable(o_working)) else $error("move back");
    indexed_a: assert property (take && i_instr[15:10] == 6'h14 && !i_instr[8] && i_ext_en && i_instr[7:0] <= 8'h5f
        && i_index_base + i_instr[7:0] != WORKING_ADDR |=> o_rd_en
        && o_rd_addr == $past(i_index_base) + $past(i_instr[7:0])) else $error("indexed address");
    ff_src_a: assert property (take && i_instr[15:12] == 4'hc && i_instr[11:0] != WORKING_ADDR |=> o_rd_en
        && o_rd_addr == $past(i_instr[11:0]) ##3 o_second_word_wait && !o_done) else $error("pair source");
    ff_dst_a: assert property (take2 && i_instr[15:12] == 4'hf && i_instr[11:0] != WORKING_ADDR |=> !o_rd_en
        ##2 o_wr_en && o_wr_addr == $past(i_instr[11:0], 3) ##1 o_done && !o_second_word_wait)
        else $error("pair destination");

    cover property (take2 && i_instr[15:12] == 4'hf);
    cover property (take && i_ext_en && i_instr[15:8] == 8'h50 && i_instr[7:0] <= 8'h5f);
    cover property (take && i_instr[15:8] == 8'h01);
endmodule

bind dmx_exec dmx_exec_chk #(.WORKING_ADDR(WORKING_ADDR), .ADDR_W(ADDR_W)) dmx_exec_chk_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_instr(i_instr), .i_instr_valid(i_instr_valid),
    .i_ext_en(i_ext_en), .i_index_base(i_index_base), .o_rd_en(o_rd_en), .o_rd_addr(o_rd_addr),
    .i_rd_data(i_rd_data), .o_wr_en(o_wr_en), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
    .o_working(o_working), .o_bank_select_register(o_bank_select_register), .o_flag_n(o_flag_n),
    .o_flag_z(o_flag_z), .o_phase(o_phase), .o_second_word_wait(o_second_word_wait), .o_done(o_done));

// ### data_move_instr_exec_tb.sv
// Self-checking bench for the data-move execute block.
// Assumes dmx_exec at its default working register address.
`timescale 1ns/1ps
module data_move_instr_exec_tb;
    import dmx_pkg::*;
    localparam logic [11:0] WA = WORKING_ADDR_DFLT;
    // Stand-in floor for the program counter and stack top bytes; the value is a plain default
    localparam logic [11:0] RSVD_DST = 12'hff0;
    logic        i_mclk, i_rst, i_instr_valid, i_ext_en;
    logic [15:0] i_instr;
    logic [11:0] i_index_base, o_rd_addr, o_wr_addr, era, ewa;
    logic [7:0]  i_rd_data, o_wr_data, o_working, o_bank_select_register;
    logic        o_rd_en, o_wr_en, o_flag_n, o_flag_z, o_second_word_wait, o_done;
    logic [1:0]  o_phase;
    logic [7:0]  mem [4096];
    logic [7:0]  w, bank_select_register, rdv, ffd, ewd;
    logic        fn, fz, ffw, edn, erd, ewe;
    logic [31:0] r;
    int          fails, checked;

    dmx_exec dmx_exec_inst (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_instr(i_instr), .i_instr_valid(i_instr_valid),
        .i_ext_en(i_ext_en), .i_index_base(i_index_base), .o_rd_en(o_rd_en), .o_rd_addr(o_rd_addr),
        .i_rd_data(i_rd_data), .o_wr_en(o_wr_en), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
        .o_working(o_working), .o_bank_select_register(o_bank_select_register), .o_flag_n(o_flag_n),
        .o_flag_z(o_flag_z), .o_phase(o_phase), .o_second_word_wait(o_second_word_wait), .o_done(o_done));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // Stale data is inverted so a late sample cannot pass
    always @(posedge i_mclk) i_rd_data <= o_rd_en ? rdv : ~i_rd_data;

    // ------------------------------------------------------------
    // Reference model and checks
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Software never aims a pair move at the reserved top bytes
    function automatic logic [11:0] legal_dst(input logic [11:0] d);
        return (d >= RSVD_DST) ? (d - 12'h100) : d;
    endfunction
    function automatic logic [11:0] ea(input logic [7:0] f, input logic a, input logic e, input logic [11:0] ib);
        if (a)
            return {bank_select_register[3:0], f};
        if (e && f <= 8'h5f)
            return ib + 12'(f);
        return {f[7] ? 4'hf : 4'h0, f};
    endfunction
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic issue(input logic [15:0] iw, input logic v, input logic e);
        logic [11:0] ib;
        logic [11:0] ad;
        ib = {1'b0, r[10:0]};
        r = lfsr(r);
        i_instr <= iw;
        i_instr_valid <= v;
        i_ext_en <= e;
        i_index_base <= ib;
        @(negedge i_mclk);
        chk(o_working, w);
        chk(o_bank_select_register, bank_select_register);
        chk({o_flag_n, o_flag_z}, {fn, fz});
        chk({o_done, o_second_word_wait}, {edn, ffw});
        {erd, ewe, edn} = 3'h0;
        ad = ea(iw[7:0], iw[8], e, ib);
        if (v && ffw) begin
            ffw = 1'b0;
            edn = iw[15:12] == 4'hf;
            ewe = edn && iw[11:0] != WA;
            {ewa, ewd} = {iw[11:0], ffd};
            if (ewe) mem[ewa] = ffd;
            else if (edn) w = ffd;
        end else if (v) begin
            casez (iw[15:8])
                8'b0101_00??: begin
                    {erd, era} = {ad != WA, ad};
                    rdv = erd ? mem[ad] : w;
                    {ewe, ewa, ewd} = {iw[9] && erd, ad, rdv};
                    if (!iw[9]) w = rdv;
                    {fn, fz, edn} = {rdv[7], rdv == 8'h00, 1'b1};
                end
                8'b0110_111?: begin
                    {ewe, ewa, ewd, edn} = {ad != WA, ad, w, 1'b1};
                    if (ewe) mem[ad] = w;
                end
                8'h0e: {w, edn} = {iw[7:0], 1'b1};
                8'h01: {bank_select_register, edn} = {4'h0, iw[3:0], 1'b1};
                8'b1100_????: begin
                    {erd, era} = {iw[11:0] != WA, iw[11:0]};
                    rdv = erd ? mem[era] : w;
                    {ffd, ffw} = {rdv, 1'b1};
                end
                default: ;
            endcase
        end
        @(posedge i_mclk);
        @(negedge i_mclk);
        chk({o_rd_en, o_rd_addr & {12{erd}}}, {erd, era & {12{erd}}});
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        chk({o_wr_en, o_wr_data & {8{ewe}}}, {ewe, ewd & {8{ewe}}});
        chk(o_wr_addr & {12{ewe}}, ewa & {12{ewe}});
        chk(o_phase, 2'h3);
        @(posedge i_mclk);
    endtask

    initial begin
        {i_rst, i_instr, i_instr_valid, i_ext_en, i_index_base, i_rd_data} = {1'b1, 38'h0};
        {w, bank_select_register, fn, fz, ffw, edn, fails, checked} = '0;
        r = 32'h000145a6;
        for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 7) ^ 8'h5a;
        repeat (5) @(posedge i_mclk);
        i_rst <= 1'b0;
        // Corner cases: bank edges, index boundary, pair ends, working register
        issue(16'h01f5, 1'b1, 1'b0);
        issue(16'h0e5a, 1'b1, 1'b0);
        issue(16'h6f10, 1'b1, 1'b0);
        issue(16'h5110, 1'b1, 1'b0);
        issue(16'h5310, 1'b1, 1'b0);
        issue(16'h6e10, 1'b1, 1'b1);
        issue(16'h505f, 1'b1, 1'b1);
        issue(16'h5060, 1'b1, 1'b1);
        issue(16'h50e8, 1'b1, 1'b0);
        issue(16'hc000, 1'b1, 1'b0);
        issue(16'h0000, 1'b0, 1'b0);
        issue(16'hffef, 1'b1, 1'b0);
        issue(16'hcfe8, 1'b1, 1'b0);
        issue(16'hf123, 1'b1, 1'b0);
        issue(16'hc123, 1'b1, 1'b0);
        issue(16'hffe8, 1'b1, 1'b0);
        issue(16'h3a00, 1'b1, 1'b0);
        // A wrong second word drops the pair and is not run itself
        issue(16'hc456, 1'b1, 1'b0);
        issue(16'h0e33, 1'b1, 1'b0);
        for (int n = 0; n < 300; n++) begin
            r = lfsr(r);
            case (r[18:16])
                3'h0: issue({6'h14, r[9:0]}, r[20] | r[21], r[22]);
                3'h1: issue({7'h37, r[8:0]}, 1'b1, r[22]);
                3'h2: issue({8'h0e, r[7:0]}, 1'b1, r[22]);
                3'h3: issue({8'h01, r[7:0]}, 1'b1, r[22]);
                default: begin
                    issue({4'hc, r[11:0]}, 1'b1, r[22]);
                    issue({4'hf, legal_dst(r[27:16])}, 1'b1, r[22]);
                end
            endcase
        end
        issue(16'h0000, 1'b0, 1'b0);
        end_of_test();
    end

    // Watchdog sized well above the longest expected run
    initial begin
        repeat (8000) @(posedge i_mclk);
        fails++;
        end_of_test();
    end
endmodule
